//--- inc/mtpi_pkg.sv
// constants shared by the transmit port and its data buffer
// assumes a 125 MHz system clock sampling the phy transmit clock as a plain input
package mtpi_pkg;

  // ----------------------------------------------------------------
  // link clock rates supplied by the phy (mhz x 10)
  // ----------------------------------------------------------------
  localparam int unsigned MII_10M_CLK_MHZ_X10  = 25;
  localparam int unsigned MII_100M_CLK_MHZ_X10 = 250;
  localparam int unsigned SERIAL_CLK_MHZ_X10   = 100;

  // ----------------------------------------------------------------
  // data path shape
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_W     = 9;   // byte plus end-of-frame mark
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned LAST_BIT   = 8;   // position of end-of-frame mark
  localparam int unsigned NIBBLE_W   = 4;

  // ----------------------------------------------------------------
  // units left after the first one of a byte
  // ----------------------------------------------------------------
  localparam logic [2:0] MII_UNITS_LEFT    = 3'h1;
  localparam logic [2:0] SERIAL_UNITS_LEFT = 3'h7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] TX_DATA_RST  = 4'h0;
  localparam logic [7:0] SHIFT_RST    = 8'h00;
  localparam logic [2:0] CNT_RST      = 3'h0;
  localparam logic [2:0] SYNC_RST     = 3'h0;

  // ----------------------------------------------------------------
  // transmit state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    MTPI_IDLE = 1'b0,
    MTPI_SEND = 1'b1
  } mtpi_state_t;

endpackage : mtpi_pkg

//--- src/mtpi_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; writer and reader on the same domain
`timescale 1ns/1ps
`default_nettype none
module mtpi_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  // drain side
  output logic      [WIDTH-1:0] rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      wr_ptr_next;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      rd_ptr_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // flags and pointer advance
  // ----------------------------------------------------------------
  // extra pointer bit tells full from empty without a counter
  always_comb begin
    empty       = (wr_ptr_reg == rd_ptr_reg);
    full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    wr_ready    = !full;
    rd_valid    = !empty;
    push        = wr_valid && !full;
    pop         = rd_ready && !empty;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    rd_data     = mem[rd_ptr_reg[AW-1:0]];
  end

  // pointer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= wr_data;
    end
  end

endmodule : mtpi_fifo
`default_nettype wire

//--- src/mtpi_tx_port.sv
// transmit side of one mii / 10 mbps serial port
// assumes the frame bytes, preamble included, arrive from the mac core on clk;
// the phy transmit clock is sampled as an asynchronous input; eight copies make the port set
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: port outputs timed by its own phy clock
// RULE2: phy gives 2.5 or 25 MHz in mii
// RULE3: phy gives 10 MHz in serial mode
// RULE4: outputs change on phy clock rising edge
// RULE5: mii sends one nibble per clock
// RULE6: serial sends one bit on bit 0
// RULE7: valid marks data lines carrying frame data
// RULE8: unused port clock tied to fixed level
// RULE9: valid from first preamble unit to last
// RULE10: serial upper bits low; low nibble first
module mtpi_tx_port (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // mode, level from the mac configuration
  input  wire logic       serial_mode,
  // frame byte stream from the mac core
  input  wire logic [7:0] frame_byte,
  input  wire logic       frame_last,
  input  wire logic       frame_valid,
  output logic            frame_ready,
  // phy pins
  input  wire logic       phy_tx_clock_in,
  output logic      [3:0] tx_data_port,
  output logic            tx_valid_out,
  // status
  output logic            tx_underrun
);

  // ----------------------------------------------------------------
  // phy clock synchroniser and edge finder
  // ----------------------------------------------------------------
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       tx_edge;

  // only the second and third stage feed the edge detector
  always_comb begin
    sync_next = {sync_reg[1:0], phy_tx_clock_in};
    tx_edge   = sync_reg[1] && !sync_reg[2]; // see RULE4
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_reg <= mtpi_pkg::SYNC_RST;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // ----------------------------------------------------------------
  // byte buffer
  // ----------------------------------------------------------------
  logic [mtpi_pkg::FIFO_W-1:0] fifo_out;
  logic                        fifo_valid;
  logic                        pop;

  mtpi_fifo #(
    .WIDTH (mtpi_pkg::FIFO_W),
    .DEPTH (mtpi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .wr_data  ({frame_last, frame_byte}),
    .wr_valid (frame_valid),
    .wr_ready (frame_ready),
    .rd_data  (fifo_out),
    .rd_valid (fifo_valid),
    .rd_ready (pop)
  );

  // ----------------------------------------------------------------
  // unit serialiser
  // ----------------------------------------------------------------
  mtpi_pkg::mtpi_state_t state_reg;
  mtpi_pkg::mtpi_state_t state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       last_reg;
  logic       last_next;
  logic       mode_reg;
  logic       mode_next;
  logic [3:0] data_reg;
  logic [3:0] data_next;
  logic       valid_reg;
  logic       valid_next;
  logic       under_reg;
  logic       under_next;
  logic       need_byte;
  logic       start_mode;

  // first unit of a byte in the chosen width; serial keeps bits 3:1 low
  function automatic logic [3:0] first_unit(input logic [7:0] b, input logic ser);
    first_unit = ser ? {3'h0, b[0]} : b[3:0]; // see RULE10
  endfunction : first_unit

  // tx_data_port and tx_valid_out move only on a sampled phy rising edge
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    last_next  = last_reg;
    mode_next  = mode_reg;
    data_next  = data_reg;
    valid_next = valid_reg;
    under_next = 1'b0;
    // mode is taken only at frame start so a change cannot split a frame
    start_mode = (state_reg == mtpi_pkg::MTPI_IDLE) ? serial_mode : mode_reg;
    need_byte  = (state_reg == mtpi_pkg::MTPI_IDLE) || ((cnt_reg == mtpi_pkg::CNT_RST) && !last_reg);
    pop        = tx_edge && need_byte && fifo_valid;
    if (tx_edge) begin // see RULE1
      if ((state_reg == mtpi_pkg::MTPI_SEND) && (cnt_reg != mtpi_pkg::CNT_RST)) begin
        // low nibble went first, high nibble or next bit follows
        data_next  = mode_reg ? {3'h0, shift_reg[0]} : shift_reg[3:0]; // see RULE5
        shift_next = mode_reg ? {1'b0, shift_reg[7:1]} : {4'h0, shift_reg[7:4]}; // see RULE6
        cnt_next   = cnt_reg - 1'b1;
      end else if (pop) begin
        mode_next  = start_mode;
        data_next  = first_unit(fifo_out[7:0], start_mode); // see RULE10
        shift_next = start_mode ? {1'b0, fifo_out[7:1]} : {4'h0, fifo_out[7:4]};
        cnt_next   = start_mode ? mtpi_pkg::SERIAL_UNITS_LEFT : mtpi_pkg::MII_UNITS_LEFT;
        last_next  = fifo_out[mtpi_pkg::LAST_BIT];
        valid_next = 1'b1; // see RULE9
        state_next = mtpi_pkg::MTPI_SEND;
      end else begin
        // frame over, or the mac starved us mid-frame
        under_next = (state_reg == mtpi_pkg::MTPI_SEND) && !last_reg;
        data_next  = mtpi_pkg::TX_DATA_RST; // see RULE7
        valid_next = 1'b0; // see RULE9
        last_next  = 1'b0;
        state_next = mtpi_pkg::MTPI_IDLE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= mtpi_pkg::MTPI_IDLE;
      shift_reg <= mtpi_pkg::SHIFT_RST;
      cnt_reg   <= mtpi_pkg::CNT_RST;
      last_reg  <= 1'b0;
      mode_reg  <= 1'b0;
      data_reg  <= mtpi_pkg::TX_DATA_RST;
      valid_reg <= 1'b0;
      under_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      last_reg  <= last_next;
      mode_reg  <= mode_next;
      data_reg  <= data_next;
      valid_reg <= valid_next;
      under_reg <= under_next;
    end
  end

  assign tx_data_port = data_reg;
  assign tx_valid_out = valid_reg;
  assign tx_underrun  = under_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pin_moves_on_edge;
    @(posedge clk) disable iff (!rst_b)
    (!$stable(tx_data_port) || !$stable(tx_valid_out)) |-> $past(tx_edge);
  endproperty
  a_pin_moves_on_edge: assert property (p_pin_moves_on_edge) // see RULE1
    else $error("phy outputs changed without a phy clock edge");

  // judged on the synchronised pin itself, so a wrong edge decode shows up
  property p_edge_is_rising;
    @(posedge clk) disable iff (!rst_b)
    (!$stable(tx_data_port) || !$stable(tx_valid_out)) |-> $rose(sync_reg[2]);
  endproperty
  a_edge_is_rising: assert property (p_edge_is_rising) // see RULE4
    else $error("phy outputs moved without a rising phy clock edge");

  property p_mii_low_nibble;
    @(posedge clk) disable iff (!rst_b)
    (pop && !start_mode) |=> (tx_data_port == $past(fifo_out[3:0])) && tx_valid_out;
  endproperty
  a_mii_low_nibble: assert property (p_mii_low_nibble) // see RULE5
    else $error("mii first nibble is not the low nibble");

  property p_mii_high_nibble;
    @(posedge clk) disable iff (!rst_b)
    (tx_edge && state_reg == mtpi_pkg::MTPI_SEND && !mode_reg && cnt_reg == mtpi_pkg::MII_UNITS_LEFT)
      |=> tx_data_port == $past(shift_reg[3:0]);
  endproperty
  a_mii_high_nibble: assert property (p_mii_high_nibble) // see RULE10
    else $error("mii second nibble wrong");

  property p_serial_bit0;
    @(posedge clk) disable iff (!rst_b)
    (pop && start_mode) |=> tx_data_port == {3'h0, $past(fifo_out[0])};
  endproperty
  a_serial_bit0: assert property (p_serial_bit0) // see RULE6
    else $error("serial first bit wrong or upper lines driven");

  property p_idle_lines_low;
    @(posedge clk) disable iff (!rst_b)
    (!tx_valid_out || mode_reg) |-> tx_data_port[3:1] == 3'h0;
  endproperty
  a_idle_lines_low: assert property (p_idle_lines_low) // see RULE7
    else $error("data lines active outside valid mii data");

  property p_valid_ends_clean;
    @(posedge clk) disable iff (!rst_b)
    $fell(tx_valid_out) |-> $past(cnt_reg == mtpi_pkg::CNT_RST) && ($past(last_reg) || tx_underrun);
  endproperty
  a_valid_ends_clean: assert property (p_valid_ends_clean) // see RULE9
    else $error("valid dropped before the last unit");

  c_mii_frame:    cover property (@(posedge clk) disable iff (!rst_b) $fell(tx_valid_out) && !mode_reg);
  c_serial_frame: cover property (@(posedge clk) disable iff (!rst_b) $fell(tx_valid_out) && mode_reg);
  c_underrun:     cover property (@(posedge clk) disable iff (!rst_b) tx_underrun);
  c_fifo_full:    cover property (@(posedge clk) disable iff (!rst_b) !frame_ready);

endmodule : mtpi_tx_port
`default_nettype wire

//--- verif/mtpi_phy_model.sv
// phy-side model for one transmit port: makes the link clock, captures units
// assumes the port settles its pins well inside one link clock period
`timescale 1ns/1ps
`default_nettype none
module mtpi_phy_model (
  // control from the bench
  input  wire logic       run,
  // phy pins
  output logic            phy_clk,
  input  wire logic [3:0] tx_data,
  input  wire logic       tx_valid
);
  logic [3:0] units[$];
  int         n_ends;
  logic       valid_d;

  // 80 ns clock, one unit per period in either mode; rate scaled for run time
  // one fixed rate stands in for 2.5/25 mhz mii and 10 mhz serial
  initial begin
    phy_clk = 1'b0;
    n_ends  = 0;
    valid_d = 1'b0;
    #3;
    forever begin
      #40;
      if (run) phy_clk = ~phy_clk;  // stands at a fixed level when idle
    end
  end

  // sample on our own rising edge, as a real phy does; count frame ends
  always @(posedge phy_clk) begin
    if (tx_valid === 1'b1) units.push_back(tx_data);
    if (valid_d === 1'b1 && tx_valid !== 1'b1) n_ends++;
    valid_d = tx_valid;
  end
endmodule : mtpi_phy_model
`default_nettype wire

//--- verif/test_mii_transmit_port_interface.sv
// self-checking bench for one transmit port with a phy model on its far side
// assumes 125 MHz clk and an 80 ns link clock unrelated in phase
`timescale 1ns/1ps
`default_nettype none
module test_mii_transmit_port_interface;
  logic       clk, rst_b, serial_mode, frame_last, frame_valid, run;
  logic [7:0] frame_byte;
  logic       frame_ready, phy_clk, tx_valid_out, tx_underrun;
  logic [3:0] tx_data_port;
  logic [3:0] exp_q[$];
  logic [31:0] r;
  int         n_errors, tests_run, seed, n_under, j;

  mtpi_tx_port uut (.clk(clk), .rst_b(rst_b), .serial_mode(serial_mode), .frame_byte(frame_byte),
    .frame_last(frame_last), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .phy_tx_clock_in(phy_clk), .tx_data_port(tx_data_port), .tx_valid_out(tx_valid_out),
    .tx_underrun(tx_underrun));
  mtpi_phy_model phy (.run(run), .phy_clk(phy_clk), .tx_data(tx_data_port), .tx_valid(tx_valid_out));

  always #4 clk = ~clk;
  // underrun pulses are one clk long, so count them every edge
  always @(posedge clk) if (tx_underrun === 1'b1) n_under++;

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic fail(input string msg);
    n_errors++;
    $display("[ERR] %0t %s", $time, msg);
    complete_run;
  endtask : fail

  task automatic cmp_unit(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t unit got %h expected %h", $time, got, exp);
    end
  endtask : cmp_unit

  task automatic cmp_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : cmp_flag

  // unit k of a byte on the wire: low nibble first, or lsb first on bit 0
  function automatic logic [3:0] unit_of(input logic [7:0] b, input int k, input logic ser);
    if (ser) return {3'h0, b[k]};
    return k ? b[7:4] : b[3:0];
  endfunction : unit_of

  // offer one byte from a clk edge; hold it until the fifo has room
  task automatic put(input logic [7:0] b, input logic l);
    int i;
    logic ok;
    frame_byte  <= b;
    frame_last  <= l;
    frame_valid <= 1'b1;
    i = 0;
    do begin
      #1 ok = frame_ready;
      @(posedge clk);
      i++;
    end while (ok !== 1'b1 && i < 5000);
    if (ok !== 1'b1) fail("byte refused too long");
  endtask : put

  // one frame: optional stall of the link clock so the fifo fills first
  task automatic run_frame(input int len, input logic ser, input logic fin, input logic stall);
    int i, k, ends0, under0;
    logic [7:0] b;
    phy.units.delete();
    exp_q.delete();
    ends0  = phy.n_ends;
    under0 = n_under;
    @(posedge clk);
    serial_mode <= ser;
    run <= !stall;
    repeat (20) @(posedge clk);
    for (i = 0; i < len; i++) begin
      b = 8'($random(seed));
      for (k = 0; k < (ser ? 8 : 2); k++) exp_q.push_back(unit_of(b, k, ser));
      put(b, fin && (i == len - 1));
    end
    frame_valid <= 1'b0;
    if (stall) begin
      #1 cmp_flag(frame_ready, 1'b0);
      cmp_flag(tx_valid_out, 1'b0);
      @(posedge clk);
      run <= 1'b1;
    end
    i = 0;
    while (!(phy.units.size() >= exp_q.size() && phy.n_ends != ends0) && i < 8000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 8000) fail("frame never completed");
    // look after the edge so outputs launched on it have settled
    #1;
    cmp_flag(phy.units.size() == exp_q.size(), 1'b1);
    foreach (exp_q[n]) cmp_unit(phy.units[n], exp_q[n]);
    cmp_flag(phy.n_ends == ends0 + 1, 1'b1);
    cmp_unit(tx_data_port, 4'h0);
    cmp_flag(n_under == under0 + (fin ? 0 : 1), 1'b1);
  endtask : run_frame

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    serial_mode = 1'b0;
    frame_byte = 8'h00;
    frame_last = 1'b0;
    frame_valid = 1'b0;
    run = 1'b1;
    seed = 76;
    n_errors = 0;
    tests_run = 0;
    n_under = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 cmp_flag(frame_ready, 1'b1);
    cmp_flag(tx_valid_out, 1'b0);
    run_frame(1, 1'b0, 1'b1, 1'b0);
    run_frame(1, 1'b1, 1'b1, 1'b0);
    run_frame(16, 1'b0, 1'b1, 1'b1);
    run_frame(20, 1'b1, 1'b1, 1'b0);
    run_frame(2, 1'b0, 1'b0, 1'b0);
    for (j = 0; j < 10; j++) begin
      r = $random(seed);
      run_frame(int'(r[7:0]) % 20 + 1, r[8], 1'b1, 1'b0);
    end
    complete_run;
  end
endmodule : test_mii_transmit_port_interface
`default_nettype wire
